// ### mil_core_model.sv
// Behavioural processor core that answers the vector and return loads.
module mil_core_model
    import mil_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic vector_load,
    input wire logic [12:0] vector_addr,
    input wire logic ret_load,
    input wire logic [12:0] ret_addr,
    output logic instr_done,
    output logic [12:0] core_pc
);
    // ====
    // Instruction boundaries come every cycle, or every second cycle when slow.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_done <= 1'h0;
        end else begin
            instr_done <= slow ? ~instr_done : 1'h1;
        end
    end
    // The program counter follows the loads that the interrupt logic issues.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_pc <= 13'h0000;
        end else if (vector_load) begin
            core_pc <= vector_addr;
        end else if (ret_load) begin
            core_pc <= ret_addr;
        end else if (instr_done) begin
            core_pc <= core_pc + 13'h0001;
        end
    end
endmodule

// ### mil_edge_detect.sv
// Edge detector for the external interrupt pin and the upper port pins.
module mil_edge_detect #(
    parameter int CHG_W = 4
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ext_irq_pin,
    input wire logic ext_edge_select,
    input wire logic [CHG_W-1:0] pin_group_b_hi,
    output logic ext_edge,
    output logic pin_change
);

    logic pin_q;
    logic [CHG_W-1:0] grp_q;
    logic armed;

    // Previous samples; the armed bit suppresses a false edge after reset.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_q <= 1'b0;
            grp_q <= '0;
            armed <= 1'b0;
        end else begin
            pin_q <= ext_irq_pin;
            grp_q <= pin_group_b_hi;
            armed <= 1'b1;
        end
    end

    // One-cycle pulses: selected edge of the pin, any change on the group.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_edge <= 1'b0;
            pin_change <= 1'b0;
        end else begin
            if (ext_edge_select) begin
                ext_edge <= armed & ext_irq_pin & ~pin_q;
            end else begin
                ext_edge <= armed & ~ext_irq_pin & pin_q;
            end
            pin_change <= armed & (|(pin_group_b_hi ^ grp_q));
        end
    end

endmodule

// ### mil_interrupt_logic.sv
// Interrupt controller: flags, enables, vectoring, return and wake-up.
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`include "mil_regs.svh"

// Operation
// - Fourteen interrupt sources, each with its own flag and enable bit.
// - A flag sets on its event whatever any enable holds.
// - Global enable one allows unmasked interrupts; zero blocks every interrupt.
// - Global enable with any enabled flag set takes the interrupt at once.
// - Every reset clears the global enable.
// - Entry clears global enable, pushes return address, loads vector 0004h.
// - Return-from-interrupt leaves the routine and sets the global enable.
// - Pin edge or port change reaches the vector in three or four cycles.
// - Peripheral flags and enables in two register pairs, gated by peripheral enable.
// - External pin interrupts on the edge chosen by edge select; sets its flag.
// - The external pin interrupt has its own enable at control bit 4.
// - Pin wakes power-down only when enabled; global enable decides the branch.
// - Timer0 wrap from all ones to zero sets its flag; own enable.
// - Any change on upper port pins sets the change flag; own enable.
// - Entry saves only the return address; other context is software's job.
// - After an interrupt wake-up the causing flag bits stay set.
// - Wake with global enable clear continues; set runs next instruction then vectors.
module mil_interrupt_logic
    import mil_pkg::*;
#(
    parameter int PFA_W = 8,
    parameter int PFB_W = 3,
    parameter int PC_W = 13,
    parameter int STACK_DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ext_irq_pin,
    input wire logic [3:0] pin_group_b_hi,
    input wire logic [7:0] timer0_count,
    input wire logic [PFA_W-1:0] periph_a_event,
    input wire logic [PFB_W-1:0] periph_b_event,
    input wire logic instr_done,
    input wire logic [PC_W-1:0] core_pc,
    input wire logic return_from_irq_op,
    input wire logic sleep_op,
    output logic vector_load,
    output logic [PC_W-1:0] vector_addr,
    output logic ret_load,
    output logic [PC_W-1:0] ret_addr,
    output logic core_sleeping,
    output logic core_wake,
    output logic irq
);

    localparam int CW = $clog2(STACK_DEPTH) + 1;

    // ==========================================================
    // Declarations.
    logic [7:0] irq_control_reg;
    logic [7:0] next_ctrl;
    logic [7:0] option_reg;
    logic [PFA_W-1:0] periph_flag_reg_a;
    logic [PFB_W-1:0] periph_flag_reg_b;
    logic [PFA_W-1:0] periph_enable_reg_a;
    logic [PFB_W-1:0] periph_enable_reg_b;
    logic [3:0] ev_status;
    logic [3:0] ev_mask;
    logic [3:0] ev_set;
    mil_state_e state;
    mil_state_e next_state;
    logic [7:0] t0_q;
    logic t0_wrap;
    logic ext_edge;
    logic pin_change;
    logic pending;
    logic take;
    logic ret_take;
    logic wr_en;
    logic [31:0] rd_mux;
    logic [PC_W-1:0] stk_top;
    logic [CW-1:0] stk_count;
    logic stk_ovf;
    logic stk_unf;
    logic global_irq_enable;
    logic peripheral_irq_enable;

    assign global_irq_enable = irq_control_reg[`MIL_B_GEN];
    assign peripheral_irq_enable = irq_control_reg[`MIL_B_PEN];

    // ==========================================================
    // Event sources.

    // Pin edge and port change detection.
    mil_edge_detect #(
        .CHG_W(4)
    ) u_edge (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ext_irq_pin(ext_irq_pin),
        .ext_edge_select(option_reg[`MIL_B_EDGE]),
        .pin_group_b_hi(pin_group_b_hi),
        .ext_edge(ext_edge),
        .pin_change(pin_change)
    );

    // Timer0 wrap detection on the previous count.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            t0_q <= `MIL_T0_ZERO;
        end else begin
            t0_q <= timer0_count;
        end
    end

    assign t0_wrap = (t0_q == `MIL_T0_TOP) && (timer0_count == `MIL_T0_ZERO);

    // ==========================================================
    // Avalon-MM slave: one wait cycle, then the access completes.

    // Wait request drops for one cycle after a request is seen.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    assign wr_en = avs_write & ~avs_waitrequest & avs_byteenable[0];

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address == `MIL_OFF_CTRL) begin
            rd_mux[7:0] = irq_control_reg;
        end else if (avs_address == `MIL_OFF_OPT) begin
            rd_mux[7:0] = option_reg;
        end else if (avs_address == `MIL_OFF_PFA) begin
            rd_mux[PFA_W-1:0] = periph_flag_reg_a;
        end else if (avs_address == `MIL_OFF_PFB) begin
            rd_mux[PFB_W-1:0] = periph_flag_reg_b;
        end else if (avs_address == `MIL_OFF_PEA) begin
            rd_mux[PFA_W-1:0] = periph_enable_reg_a;
        end else if (avs_address == `MIL_OFF_PEB) begin
            rd_mux[PFB_W-1:0] = periph_enable_reg_b;
        end else if (avs_address == `MIL_OFF_EVST) begin
            rd_mux[3:0] = ev_status;
        end else if (avs_address == `MIL_OFF_EVMSK) begin
            rd_mux[3:0] = ev_mask;
        end else if (avs_address == `MIL_OFF_CORE) begin
            rd_mux[1:0] = state;
            rd_mux[8 +: CW] = stk_count;
        end
    end

    // Read data is captured while waitrequest is still high.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & avs_waitrequest) begin
            avs_readdata <= rd_mux;
        end
    end

    // ==========================================================
    // Flags and enables.

    // Control register: hardware sets win over a software write.
    always_comb begin
        next_ctrl = irq_control_reg;
        if (wr_en && avs_address == `MIL_OFF_CTRL) begin
            next_ctrl = avs_writedata[7:0];
        end
        if (ret_take) begin
            next_ctrl[`MIL_B_GEN] = 1'b1;
        end
        if (take) begin
            next_ctrl[`MIL_B_GEN] = 1'b0;
        end
        if (t0_wrap) begin
            next_ctrl[`MIL_B_T0FL] = 1'b1;
        end
        if (ext_edge) begin
            next_ctrl[`MIL_B_XFL] = 1'b1;
        end
        if (pin_change) begin
            next_ctrl[`MIL_B_CFL] = 1'b1;
        end
    end

    // Control register; reset clears the global enable.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_control_reg <= `MIL_RST_CTRL;
        end else begin
            irq_control_reg <= next_ctrl;
        end
    end

    // Option register holding the pin edge select.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            option_reg <= `MIL_RST_OPT;
        end else if (wr_en && avs_address == `MIL_OFF_OPT) begin
            option_reg <= avs_writedata[7:0];
        end
    end

    // Peripheral flags: writable, and events always set them.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            periph_flag_reg_a <= '0;
            periph_flag_reg_b <= '0;
        end else begin
            if (wr_en && avs_address == `MIL_OFF_PFA) begin
                periph_flag_reg_a <= avs_writedata[PFA_W-1:0] | periph_a_event;
            end else begin
                periph_flag_reg_a <= periph_flag_reg_a | periph_a_event;
            end
            if (wr_en && avs_address == `MIL_OFF_PFB) begin
                periph_flag_reg_b <= avs_writedata[PFB_W-1:0] | periph_b_event;
            end else begin
                periph_flag_reg_b <= periph_flag_reg_b | periph_b_event;
            end
        end
    end

    // Peripheral enables.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            periph_enable_reg_a <= '0;
            periph_enable_reg_b <= '0;
        end else begin
            if (wr_en && avs_address == `MIL_OFF_PEA) begin
                periph_enable_reg_a <= avs_writedata[PFA_W-1:0];
            end
            if (wr_en && avs_address == `MIL_OFF_PEB) begin
                periph_enable_reg_b <= avs_writedata[PFB_W-1:0];
            end
        end
    end

    // Any enabled source; peripherals also need the peripheral enable.
    assign pending = (irq_control_reg[`MIL_B_T0FL] & irq_control_reg[`MIL_B_T0EN])
        | (irq_control_reg[`MIL_B_XFL] & irq_control_reg[`MIL_B_XEN])
        | (irq_control_reg[`MIL_B_CFL] & irq_control_reg[`MIL_B_CEN])
        | (peripheral_irq_enable
        & (mil_hit(8'(periph_flag_reg_a), 8'(periph_enable_reg_a))
        | mil_hit(8'(periph_flag_reg_b), 8'(periph_enable_reg_b))));

    // ==========================================================
    // Sequencer: entry, return, power-down and wake-up.

    // Entry at the next instruction boundary; a wake with enable set vectors.
    assign take = instr_done & global_irq_enable
        & (((state == MIL_ST_RUN) & pending) | (state == MIL_ST_WAKE));
    assign ret_take = return_from_irq_op & (state == MIL_ST_RUN);

    // Next state.
    always_comb begin
        next_state = state;
        case (state)
            MIL_ST_RUN: begin
                if (take) begin
                    next_state = MIL_ST_ENTRY;
                end else if (sleep_op & ~pending) begin
                    next_state = MIL_ST_SLEEP;
                end
            end
            MIL_ST_ENTRY: begin
                next_state = MIL_ST_RUN;
            end
            MIL_ST_SLEEP: begin
                if (pending) begin
                    next_state = MIL_ST_WAKE;
                end
            end
            MIL_ST_WAKE: begin
                if (take) begin
                    next_state = MIL_ST_ENTRY;
                end else if (instr_done) begin
                    next_state = MIL_ST_RUN;
                end
            end
            default: begin
                next_state = MIL_ST_RUN;
            end
        endcase
    end

    // State register.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= MIL_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Return-address stack; only the program counter is saved.
    mil_ret_stack #(
        .DEPTH(STACK_DEPTH),
        .AW(PC_W)
    ) u_stack (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .push(take),
        .pop(ret_take),
        .push_addr(core_pc),
        .top_addr(stk_top),
        .count(stk_count),
        .overflow(stk_ovf),
        .underflow(stk_unf)
    );

    // Core-facing outputs, all registered.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vector_load <= 1'b0;
            vector_addr <= `MIL_VECTOR;
            ret_load <= 1'b0;
            ret_addr <= '0;
            core_sleeping <= 1'b0;
            core_wake <= 1'b0;
        end else begin
            vector_load <= take;
            vector_addr <= `MIL_VECTOR;
            ret_load <= ret_take;
            if (ret_take) begin
                ret_addr <= stk_top;
            end
            core_sleeping <= (next_state == MIL_ST_SLEEP);
            core_wake <= (state == MIL_ST_SLEEP) & pending;
        end
    end

    // ==========================================================
    // Block interrupt: sticky events, write one to clear, set wins.
    always_comb begin
        ev_set = '0;
        ev_set[`MIL_EV_ENTRY] = take;
        ev_set[`MIL_EV_WAKE] = (state == MIL_ST_SLEEP) & pending;
        ev_set[`MIL_EV_OVF] = stk_ovf;
        ev_set[`MIL_EV_UNF] = stk_unf;
    end

    // Status and mask registers.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_status <= `MIL_RST_EV;
            ev_mask <= `MIL_RST_EV;
        end else begin
            if (wr_en && avs_address == `MIL_OFF_EVST) begin
                ev_status <= (ev_status & ~avs_writedata[3:0]) | ev_set;
            end else begin
                ev_status <= ev_status | ev_set;
            end
            if (wr_en && avs_address == `MIL_OFF_EVMSK) begin
                ev_mask <= avs_writedata[3:0];
            end
        end
    end

    // Level interrupt output.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= mil_hit({4'h0, ev_status}, {4'h0, ev_mask});
        end
    end

    // ==========================================================
    // Assertions.
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    AST_FLAG_ON_EDGE: assert property (ext_edge |=> irq_control_reg[`MIL_B_XFL])
        else $error("pin edge did not set its flag");
    AST_GIE_BLOCKS: assert property (!global_irq_enable && state == MIL_ST_RUN
        |=> !vector_load) else $error("vector taken with global enable clear");
    AST_TAKE_NOW: assert property (state == MIL_ST_RUN && global_irq_enable
        && pending && instr_done |=> vector_load && !global_irq_enable)
        else $error("enabled interrupt not taken at boundary");
    AST_ENTRY: assert property (vector_load |-> vector_addr == `MIL_VECTOR
        && !global_irq_enable && $past(stk_count) != stk_count || $past(stk_ovf))
        else $error("entry without vector, clear or push");
    AST_RETURN: assert property (ret_take && !take |=> ret_load && global_irq_enable
        && ret_addr == $past(stk_top)) else $error("return did not pop and enable");
    AST_T0_WRAP: assert property (t0_wrap |=> irq_control_reg[`MIL_B_T0FL])
        else $error("timer0 wrap flag not set");
    AST_PIN_CHANGE: assert property ($changed(pin_group_b_hi) && $past(rst_b)
        |=> ##1 irq_control_reg[`MIL_B_CFL]) else $error("port change flag not set");
    AST_WAKE: assert property (state == MIL_ST_SLEEP && pending
        |=> core_wake && state == MIL_ST_WAKE ##1 !core_wake)
        else $error("enabled source did not wake the core");
    AST_WAKE_NOGIE: assert property (state == MIL_ST_WAKE && instr_done
        && !global_irq_enable |=> state == MIL_ST_RUN && !vector_load)
        else $error("wake without global enable must continue in line");

endmodule

// ### mil_interrupt_logic_test.sv
// Self-checking bench of the interrupt logic driven against a behavioural core.
`include "mil_regs.svh"
`define CHK(g, e) check(32'(g), 32'(e))
module mil_interrupt_logic_test import mil_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // Stimulus, observed outputs and counters.
    logic sys_clk, rst_b, avs_read, avs_write, ext_irq_pin, return_from_irq_op, sleep_op, slow;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] pin_group_b_hi;
    logic [7:0] timer0_count, periph_a_event;
    logic [2:0] periph_b_event;
    logic avs_waitrequest, vector_load, ret_load, core_sleeping, core_wake, irq, instr_done;
    logic [12:0] vector_addr, ret_addr, core_pc, pc_take;
    int err_total = 0;
    int compares = 0;
    // Design and core model.
    mil_interrupt_logic dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_irq_pin(ext_irq_pin), .pin_group_b_hi(pin_group_b_hi),
        .timer0_count(timer0_count), .periph_a_event(periph_a_event),
        .periph_b_event(periph_b_event),
        .instr_done(instr_done), .core_pc(core_pc), .return_from_irq_op(return_from_irq_op),
        .sleep_op(sleep_op), .vector_load(vector_load), .vector_addr(vector_addr),
        .ret_load(ret_load), .ret_addr(ret_addr), .core_sleeping(core_sleeping),
        .core_wake(core_wake), .irq(irq));
    mil_core_model u_core (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
        .vector_load(vector_load), .vector_addr(vector_addr), .ret_load(ret_load),
        .ret_addr(ret_addr), .instr_done(instr_done), .core_pc(core_pc));
    // The clock runs at 25 MHz.
    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    // ====
    // Shared helpers: comparison, verdict and the register bus master.
    task check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task complete_run();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task give_up();
        err_total++;
        complete_run();
    endtask
    // Holds the request until waitrequest is sampled low, releases it, lets one edge pass.
    task bus(input logic wr, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 20);
        if (n >= 20) give_up();
        q = avs_readdata[7:0];
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge sys_clk);
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'h1, a, d, q);
    endtask
    task rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'h0, a, 8'h00, q);
        `CHK(q, e);
    endtask
    // Counts edges until a vector load is seen, keeping the pushed address.
    task watch(input int lim, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            if (vector_load !== 1'h1) pc_take = core_pc;
            n++;
        end while (vector_load !== 1'h1 && n < lim);
    endtask
    // ====
    // Scenarios.
    task t_reset();
        rd_chk(`MIL_OFF_CTRL, 8'h00);
        rd_chk(`MIL_OFF_OPT, 8'hFF);
        rd_chk(6'h3C, 8'h00);
        `CHK(vector_addr, `MIL_VECTOR);
        $display("reset test done");
    endtask
    task t_flags();
        int n;
        wr(`MIL_OFF_CTRL, 8'h80);
        ext_irq_pin <= 1'h1;
        timer0_count <= 8'hFF;
        @(posedge sys_clk);
        timer0_count <= 8'h00;
        pin_group_b_hi <= 4'h8;
        watch(6, n);
        `CHK(n, 6);
        rd_chk(`MIL_OFF_CTRL, 8'h87);
        wr(`MIL_OFF_OPT, 8'hBF);
        wr(`MIL_OFF_CTRL, 8'h00);
        ext_irq_pin <= 1'h0;
        repeat (3) @(posedge sys_clk);
        rd_chk(`MIL_OFF_CTRL, 8'h02);
        wr(`MIL_OFF_CTRL, 8'h00);
        ext_irq_pin <= 1'h1;
        repeat (3) @(posedge sys_clk);
        rd_chk(`MIL_OFF_CTRL, 8'h00);
        $display("flag test done");
    endtask
    task t_entry(input logic s);
        int n;
        slow <= s;
        ext_irq_pin <= 1'h1;
        wr(`MIL_OFF_CTRL, 8'h90);
        ext_irq_pin <= 1'h0;
        watch(12, n);
        if (n >= 12) give_up();
        `CHK(n == 4 || n == 5, 1'h1);
        rd_chk(`MIL_OFF_CTRL, 8'h12);
        wr(`MIL_OFF_CTRL, 8'h10);
        return_from_irq_op <= 1'h1;
        @(posedge sys_clk);
        return_from_irq_op <= 1'h0;
        @(posedge sys_clk);
        `CHK(ret_load, 1'h1);
        `CHK(ret_addr, pc_take);
        rd_chk(`MIL_OFF_CTRL, 8'h90);
        watch(6, n);
        `CHK(n, 6);
        $display("entry test done");
    endtask
    task t_irq();
        `CHK(irq, 1'h0);
        wr(`MIL_OFF_EVMSK, 8'h01);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'h1);
        wr(`MIL_OFF_EVST, 8'h01);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'h0);
        rd_chk(`MIL_OFF_EVST, 8'h00);
        $display("irq test done");
    endtask
    task t_sleep();
        int n;
        slow <= 1'h0;
        ext_irq_pin <= 1'h1;
        wr(`MIL_OFF_CTRL, 8'h10);
        sleep_op <= 1'h1;
        @(posedge sys_clk);
        sleep_op <= 1'h0;
        @(posedge sys_clk);
        `CHK(core_sleeping, 1'h1);
        ext_irq_pin <= 1'h0;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (core_wake !== 1'h1 && n < 10);
        if (n >= 10) give_up();
        watch(6, n);
        `CHK(n, 6);
        `CHK(core_sleeping, 1'h0);
        rd_chk(`MIL_OFF_CTRL, 8'h12);
        rd_chk(`MIL_OFF_EVST, 8'h02);
        wr(`MIL_OFF_CTRL, 8'h90);
        ext_irq_pin <= 1'h1;
        sleep_op <= 1'h1;
        @(posedge sys_clk);
        sleep_op <= 1'h0;
        ext_irq_pin <= 1'h0;
        watch(12, n);
        `CHK(vector_load, 1'h1);
        $display("sleep test done");
    endtask
    task t_periph();
        int n;
        wr(`MIL_OFF_CTRL, 8'h80);
        wr(`MIL_OFF_PEA, 8'h01);
        periph_a_event <= 8'h01;
        periph_b_event <= 3'h4;
        @(posedge sys_clk);
        periph_a_event <= 8'h00;
        periph_b_event <= 3'h0;
        watch(6, n);
        `CHK(n, 6);
        rd_chk(`MIL_OFF_PFA, 8'h01);
        rd_chk(`MIL_OFF_PFB, 8'h04);
        wr(`MIL_OFF_CTRL, 8'hC0);
        watch(8, n);
        `CHK(vector_load, 1'h1);
        wr(`MIL_OFF_PFA, 8'h00);
        wr(`MIL_OFF_CTRL, 8'h80);
        rst_b <= 1'h0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'h1;
        @(posedge sys_clk);
        rd_chk(`MIL_OFF_CTRL, 8'h00);
        $display("peripheral test done");
    endtask
    // Main sequence: 20 cycles of reset, then every scenario in turn.
    initial begin
        {rst_b, avs_read, avs_write, ext_irq_pin, return_from_irq_op, sleep_op, slow} = 7'h00;
        avs_address = 6'h00;
        avs_writedata = 32'h00000000;
        pin_group_b_hi = 4'h0;
        timer0_count = 8'h00;
        periph_a_event = 8'h00;
        periph_b_event = 3'h0;
        repeat (20) @(posedge sys_clk);
        rst_b <= 1'h1;
        @(posedge sys_clk);
        t_reset();
        t_flags();
        t_entry(1'h0);
        t_entry(1'h1);
        t_irq();
        t_sleep();
        t_periph();
        complete_run();
    end
endmodule

// ### mil_pkg.sv
// Types and helper functions shared by the interrupt logic.
package mil_pkg;

    // Sequencer states, Gray coded along run, entry, sleep, wake.
    typedef enum logic [1:0] {
        MIL_ST_RUN = 2'b00,
        MIL_ST_ENTRY = 2'b01,
        MIL_ST_SLEEP = 2'b11,
        MIL_ST_WAKE = 2'b10
    } mil_state_e;

    // Reports whether any flag has its enable set.
    function automatic logic mil_hit(input logic [7:0] f, input logic [7:0] e);
        return |(f & e);
    endfunction

endpackage

// ### mil_regs.svh
// Register offsets, field positions, reset values and constants of the interrupt logic.
`ifndef MIL_REGS_SVH
`define MIL_REGS_SVH

// ==========================================================
// Register byte offsets.
`define MIL_OFF_CTRL 6'h00
`define MIL_OFF_OPT 6'h04
`define MIL_OFF_PFA 6'h08
`define MIL_OFF_PFB 6'h0C
`define MIL_OFF_PEA 6'h10
`define MIL_OFF_PEB 6'h14
`define MIL_OFF_EVST 6'h18
`define MIL_OFF_EVMSK 6'h1C
`define MIL_OFF_CORE 6'h20

// ==========================================================
// Control register fields, and the option register edge select bit.
`define MIL_B_GEN 7
`define MIL_B_PEN 6
`define MIL_B_T0EN 5
`define MIL_B_XEN 4
`define MIL_B_CEN 3
`define MIL_B_T0FL 2
`define MIL_B_XFL 1
`define MIL_B_CFL 0
`define MIL_B_EDGE 6

// ==========================================================
// Event status fields.
`define MIL_EV_ENTRY 0
`define MIL_EV_WAKE 1
`define MIL_EV_OVF 2
`define MIL_EV_UNF 3

// ==========================================================
// Reset values and fixed numbers.
`define MIL_RST_CTRL 8'h00
`define MIL_RST_OPT 8'hFF
`define MIL_RST_EV 4'h0
`define MIL_VECTOR 13'h0004
`define MIL_T0_TOP 8'hFF
`define MIL_T0_ZERO 8'h00

`endif

// ### mil_ret_stack.sv
// Circular hardware stack of return addresses.
module mil_ret_stack #(
    parameter int DEPTH = 8,
    parameter int AW = 13
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic push,
    input wire logic pop,
    input wire logic [AW-1:0] push_addr,
    output logic [AW-1:0] top_addr,
    output logic [$clog2(DEPTH):0] count,
    output logic overflow,
    output logic underflow
);

    localparam int PW = $clog2(DEPTH);
    logic [AW-1:0] mem [DEPTH];
    logic [PW-1:0] sp;

    // Storage; a push past the depth overwrites the oldest entry.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[sp] <= push_addr;
        end
    end

    // Pointer and fill count.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sp <= '0;
            count <= '0;
        end else if (push) begin
            sp <= sp + 1'b1;
            if (count != (PW+1)'(DEPTH)) begin
                count <= count + 1'b1;
            end
        end else if (pop) begin
            sp <= sp - 1'b1;
            if (count != '0) begin
                count <= count - 1'b1;
            end
        end
    end

    assign top_addr = mem[sp - 1'b1];
    assign overflow = push & (count == (PW+1)'(DEPTH));
    assign underflow = pop & ~push & (count == '0);

endmodule
